// >>> src/chgcfg_top.sv
// charger and led fade configuration register bank
// Functional notes
// [R1] recharge threshold bits 4:3 of setup a: 200/300/400mV, 11 disables; default 11.
// [R2] fast-charge current bits 7:5 of setup a, 90mA up; 110/111 variant dependent.
// [R3] programmed fast-charge current is only an upper bound for regulation.
// [R4] any read or write of either charger register restarts the watchdog.
// [R5] charge voltage bits 1:0 of setup b, mapping depends on variant; default 00.
// [R6] fast-charge timer bits 3:2: 60/120/240 minutes or unlimited; default 00.
// [R7] thermal regulation point bits 5:4: 70/85/100/115 C; default 10.
// [R8] top-off timer bits 7:6: 30/60/120 minutes or disabled; default 00.
// [R9] ramp code maps 0s,0.128,0.256,0.512,0.760,1,2,4 seconds full scale.
// [R10] channel one rise bits 2:0, fall bits 5:3 of fade one; default 000.
// [R11] channel two rise bits 2:0, fall bits 5:3 of fade two; default 000.
// [R12] motor drive level bits 7:6 of fade one: 1.3/2.5/3.0V/bypass; default 10.
// [R13] channel one fades only when fade two bit 6 is set; resets 0.
// [R14] channel two fades only when fade two bit 7 is set; resets 0.
// [R15] charge watchdog runs only when regulator control bit 6 set; resets 0.
// [R16] fading steps level so full scale takes the ramp time; else immediate.
// [R17] step timing derived from the clock, within one step period.
`timescale 1ns/1ps
module chgcfg_top #(
  parameter logic HIGH_CURRENT_VARIANT = 1'b0,
  parameter int WATCHDOG_CYCLES = chgcfg_pkg::WATCHDOG_S * chgcfg_pkg::CLK_HZ,
  parameter int MINUTE_CYCLES = chgcfg_pkg::MINUTE_S * chgcfg_pkg::CLK_HZ
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [chgcfg_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [chgcfg_pkg::DATA_W-1:0] REG_WDATA,
  output logic [chgcfg_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic FAST_CHARGE_ACTIVE,
  input wire logic TOP_OFF_ACTIVE,
  output logic CHARGER_ENABLE,
  output logic [1:0] TOP_OFF_SEL,
  output logic RECHARGE_ENABLE,
  output logic [8:0] RECHARGE_MV,
  output logic [10:0] FAST_CURRENT_MAX_MA,
  output logic [12:0] CHARGE_VOLTAGE_MV,
  output logic [6:0] THERMAL_LIMIT_C,
  output logic [4:0] MOTOR_DRIVE_DV,
  output logic MOTOR_BYPASS,
  output logic FAST_TIMER_EXPIRED,
  output logic FINISH_TIMER_EXPIRED,
  output logic WATCHDOG_EXPIRED,
  output logic [6:0] CHAN_ONE_LEVEL,
  output logic [6:0] CHAN_TWO_LEVEL,
  output logic CHAN_ONE_ON,
  output logic CHAN_TWO_ON
);
  import chgcfg_pkg::*;

  typedef struct packed {
    logic [7:0] setup_a;
    logic [7:0] setup_b;
    logic [7:0] fade_one;
    logic [7:0] fade_two;
    logic [7:0] level_one;
    logic [7:0] level_two;
    logic [7:0] reg_ctrl;
    logic [7:0] rdata;
    logic [31:0] wdog;
    logic wdog_exp;
    logic [31:0] sub;
    logic [7:0] fast_min;
    logic [7:0] finish_min;
    logic fast_exp;
    logic finish_exp;
  } chgcfg_state_t;

  chgcfg_state_t state_reg;
  chgcfg_state_t state_next;
  logic chg_access;

  // minutes allowed per 2-bit timer code; zero means no limit
  function automatic logic [7:0] limit_minutes(input logic [1:0] code, input logic fast);
    logic [7:0] m;
    m = 8'h00;
    unique case (code)
      2'b00: m = fast ? 8'h3c : 8'h1e;
      2'b01: m = fast ? 8'h78 : 8'h3c;
      2'b10: m = fast ? 8'hf0 : 8'h78;
      2'b11: m = 8'h00;
    endcase
    return m;
  endfunction : limit_minutes

  // [R4] charger register access
  assign chg_access = (REG_WR || REG_RD) &&
    (REG_ADDR == CHARGER_SETUP_A_ADDR || REG_ADDR == CHARGER_SETUP_B_ADDR);

  // register writes, readback and charge timers
  always_comb begin
    logic [7:0] lim_fast;
    logic [7:0] lim_fin;
    logic minute;
    state_next = state_reg;
    lim_fast = limit_minutes(state_reg.setup_b[FAST_TIMER_SEL_LSB +: 2], 1'b1);
    lim_fin = limit_minutes(state_reg.setup_b[FINISH_TIMER_SEL_LSB +: 2], 1'b0);
    if (REG_WR) begin
      unique case (REG_ADDR)
        CHARGER_SETUP_A_ADDR: state_next.setup_a = REG_WDATA;
        CHARGER_SETUP_B_ADDR: state_next.setup_b = REG_WDATA;
        FADE_TIMING_ONE_ADDR: state_next.fade_one = REG_WDATA;
        FADE_TIMING_TWO_ADDR: state_next.fade_two = REG_WDATA;
        INDICATOR_ONE_LEVEL_ADDR: state_next.level_one = REG_WDATA;
        INDICATOR_TWO_LEVEL_ADDR: state_next.level_two = REG_WDATA;
        REGULATOR_CONTROL_ADDR: state_next.reg_ctrl = REG_WDATA;
        default: state_next.rdata = state_reg.rdata;
      endcase
    end
    // readback; unmapped pointers read zero
    if (REG_RD) begin
      unique case (REG_ADDR)
        CHARGER_SETUP_A_ADDR: state_next.rdata = state_reg.setup_a;
        CHARGER_SETUP_B_ADDR: state_next.rdata = state_reg.setup_b;
        FADE_TIMING_ONE_ADDR: state_next.rdata = state_reg.fade_one;
        FADE_TIMING_TWO_ADDR: state_next.rdata = state_reg.fade_two;
        INDICATOR_ONE_LEVEL_ADDR: state_next.rdata = state_reg.level_one;
        INDICATOR_TWO_LEVEL_ADDR: state_next.rdata = state_reg.level_two;
        REGULATOR_CONTROL_ADDR: state_next.rdata = state_reg.reg_ctrl;
        default: state_next.rdata = 8'h00;
      endcase
    end
    // [R15] watchdog gated by enable
    if (!state_reg.reg_ctrl[CHARGE_WATCHDOG_ENABLE_BIT] || chg_access) begin
      // [R4] restart on access
      state_next.wdog = '0;
      state_next.wdog_exp = 1'b0;
    end else if (state_reg.wdog >= 32'(WATCHDOG_CYCLES - 1)) begin
      state_next.wdog_exp = 1'b1;
    end else begin
      state_next.wdog = state_reg.wdog + 32'd1;
    end
    // shared minute prescaler for both charge timers
    minute = state_reg.sub >= 32'(MINUTE_CYCLES - 1);
    state_next.sub = minute ? '0 : state_reg.sub + 32'd1;
    // [R6] fast-charge duration limit
    if (!FAST_CHARGE_ACTIVE) begin
      state_next.fast_min = '0;
      state_next.fast_exp = 1'b0;
    end else if (lim_fast != 8'h00 && state_reg.fast_min >= lim_fast) begin
      state_next.fast_exp = 1'b1;
    end else if (minute) begin
      state_next.fast_min = state_reg.fast_min + 8'd1;
    end
    // [R8] top-off duration limit
    if (!TOP_OFF_ACTIVE) begin
      state_next.finish_min = '0;
      state_next.finish_exp = 1'b0;
    end else if (lim_fin != 8'h00 && state_reg.finish_min >= lim_fin) begin
      state_next.finish_exp = 1'b1;
    end else if (minute) begin
      state_next.finish_min = state_reg.finish_min + 8'd1;
    end
  end

  // state register; defaults follow the reset values
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= '0;
      state_reg.setup_a <= CHARGER_SETUP_A_RST;
      state_reg.setup_b <= CHARGER_SETUP_B_RST;
      state_reg.fade_one <= FADE_TIMING_ONE_RST;
      state_reg.fade_two <= FADE_TIMING_TWO_RST;
      state_reg.level_one <= INDICATOR_LEVEL_RST;
      state_reg.level_two <= INDICATOR_LEVEL_RST;
      state_reg.reg_ctrl <= REGULATOR_CONTROL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign REG_RDATA = state_reg.rdata;
  assign CHARGER_ENABLE = state_reg.setup_a[0];
  assign TOP_OFF_SEL = state_reg.setup_a[2:1];
  assign FAST_TIMER_EXPIRED = state_reg.fast_exp;
  assign FINISH_TIMER_EXPIRED = state_reg.finish_exp;
  assign WATCHDOG_EXPIRED = state_reg.wdog_exp;

  // [R1] recharge threshold decode
  always_comb begin
    RECHARGE_ENABLE = 1'b1;
    RECHARGE_MV = 9'd0;
    unique case (state_reg.setup_a[RESTART_LSB +: 2])
      2'b00: RECHARGE_MV = 9'd200;
      2'b01: RECHARGE_MV = 9'd300;
      2'b10: RECHARGE_MV = 9'd400;
      2'b11: RECHARGE_ENABLE = 1'b0;
    endcase
  end

  // [R2] fast current ceiling; [R3] regulation treats this only as a maximum
  always_comb begin
    FAST_CURRENT_MAX_MA = 11'd0;
    unique case (state_reg.setup_a[FAST_CUR_LSB +: 3])
      3'b000: FAST_CURRENT_MAX_MA = 11'd90;
      3'b001: FAST_CURRENT_MAX_MA = 11'd270;
      3'b010: FAST_CURRENT_MAX_MA = 11'd450;
      3'b011: FAST_CURRENT_MAX_MA = 11'd630;
      3'b100: FAST_CURRENT_MAX_MA = 11'd765;
      3'b101: FAST_CURRENT_MAX_MA = 11'd850;
      3'b110: FAST_CURRENT_MAX_MA = HIGH_CURRENT_VARIANT ? 11'd1020 : 11'd120;
      3'b111: FAST_CURRENT_MAX_MA = HIGH_CURRENT_VARIANT ? 11'd1275 : 11'd180;
    endcase
  end

  // [R5] charge voltage; [R7] thermal point; [R12] motor level
  always_comb begin
    CHARGE_VOLTAGE_MV = 13'd0;
    THERMAL_LIMIT_C = 7'd0;
    MOTOR_DRIVE_DV = 5'd0;
    MOTOR_BYPASS = 1'b0;
    unique case (state_reg.setup_b[CHARGE_VOLTAGE_SEL_LSB +: 2])
      2'b00: CHARGE_VOLTAGE_MV = HIGH_CURRENT_VARIANT ? 13'd3600 : 13'd3500;
      2'b01: CHARGE_VOLTAGE_MV = HIGH_CURRENT_VARIANT ? 13'd4150 : 13'd3850;
      2'b10: CHARGE_VOLTAGE_MV = HIGH_CURRENT_VARIANT ? 13'd4200 : 13'd4050;
      2'b11: CHARGE_VOLTAGE_MV = HIGH_CURRENT_VARIANT ? 13'd4250 : 13'd4170;
    endcase
    unique case (state_reg.setup_b[THERMAL_LIMIT_LSB +: 2])
      2'b00: THERMAL_LIMIT_C = 7'd70;
      2'b01: THERMAL_LIMIT_C = 7'd85;
      2'b10: THERMAL_LIMIT_C = 7'd100;
      2'b11: THERMAL_LIMIT_C = 7'd115;
    endcase
    unique case (state_reg.fade_one[MOTOR_DRIVE_LEVEL_LSB +: 2])
      2'b00: MOTOR_DRIVE_DV = 5'd13;
      2'b01: MOTOR_DRIVE_DV = 5'd25;
      2'b10: MOTOR_DRIVE_DV = 5'd30;
      2'b11: MOTOR_BYPASS = 1'b1;
    endcase
  end

  assign CHAN_ONE_ON = state_reg.level_one[LEVEL_ENABLE_BIT];
  assign CHAN_TWO_ON = state_reg.level_two[LEVEL_ENABLE_BIT];

  // [R10] channel one fader; [R9] times decoded inside
  chgcfg_fader #(.LEVEL_W(LEVEL_W), .TICK_W(TICK_W), .CLK_HZ(CLK_HZ)) u_fade_one (
    .clk(CLK),
    .rst_b(RST_B),
    .target(state_reg.level_one[LEVEL_W-1:0]),
    .fade_enable(state_reg.fade_two[CHAN_ONE_FADE_ENABLE_BIT]),
    .rise_time(state_reg.fade_one[RISE_TIME_LSB +: 3]),
    .fall_time(state_reg.fade_one[FALL_TIME_LSB +: 3]),
    .level(CHAN_ONE_LEVEL)
  );

  // [R11] channel two fader; [R14] own enable bit
  chgcfg_fader #(.LEVEL_W(LEVEL_W), .TICK_W(TICK_W), .CLK_HZ(CLK_HZ)) u_fade_two (
    .clk(CLK),
    .rst_b(RST_B),
    .target(state_reg.level_two[LEVEL_W-1:0]),
    .fade_enable(state_reg.fade_two[CHAN_TWO_FADE_ENABLE_BIT]),
    .rise_time(state_reg.fade_two[RISE_TIME_LSB +: 3]),
    .fall_time(state_reg.fade_two[FALL_TIME_LSB +: 3]),
    .level(CHAN_TWO_LEVEL)
  );

endmodule : chgcfg_top

// >>> src/chgcfg_pkg.sv
// package: register map, field layout, reset values and timing counts of the charger/led config bank
package chgcfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register pointers
  localparam logic [7:0] CHARGER_SETUP_A_ADDR = 8'h09;
  localparam logic [7:0] CHARGER_SETUP_B_ADDR = 8'h0a;
  localparam logic [7:0] FADE_TIMING_ONE_ADDR = 8'h0b;
  localparam logic [7:0] FADE_TIMING_TWO_ADDR = 8'h0c;
  localparam logic [7:0] INDICATOR_ONE_LEVEL_ADDR = 8'h0d;
  localparam logic [7:0] INDICATOR_TWO_LEVEL_ADDR = 8'h0e;
  localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'h05;

  // reset values
  localparam logic [7:0] CHARGER_SETUP_A_RST = 8'h1f;
  localparam logic [7:0] CHARGER_SETUP_B_RST = 8'h20;
  localparam logic [7:0] FADE_TIMING_ONE_RST = 8'h80;
  localparam logic [7:0] FADE_TIMING_TWO_RST = 8'h00;
  localparam logic [7:0] INDICATOR_LEVEL_RST = 8'h00;
  localparam logic [7:0] REGULATOR_CONTROL_RST = 8'h80;

  // field positions (low bit of each field) and the level width
  localparam int RESTART_LSB = 3;
  localparam int FAST_CUR_LSB = 5;
  localparam int CHARGE_VOLTAGE_SEL_LSB = 0;
  localparam int FAST_TIMER_SEL_LSB = 2;
  localparam int THERMAL_LIMIT_LSB = 4;
  localparam int FINISH_TIMER_SEL_LSB = 6;
  localparam int RISE_TIME_LSB = 0;
  localparam int FALL_TIME_LSB = 3;
  localparam int MOTOR_DRIVE_LEVEL_LSB = 6;
  localparam int CHAN_ONE_FADE_ENABLE_BIT = 6;
  localparam int CHAN_TWO_FADE_ENABLE_BIT = 7;
  localparam int CHARGE_WATCHDOG_ENABLE_BIT = 6;
  localparam int LEVEL_ENABLE_BIT = 7;
  localparam int LEVEL_W = 7;

  // timing: clock rate and full-scale ramp times in ms
  localparam int CLK_HZ = 20_000_000;
  localparam int RAMP_MS [8] = '{0, 128, 256, 512, 760, 1000, 2000, 4000};
  localparam int LEVEL_STEPS = 127;
  localparam int MIN_TICK = 1;
  localparam int TICK_W = 24;
  localparam int WATCHDOG_S = 5;
  localparam int MINUTE_S = 60;

  typedef enum logic [1:0] {
    CHGCFG_HOLD_T_UNUSED = 2'd0
  } chgcfg_dummy_t;

endpackage : chgcfg_pkg

// >>> src/chgcfg_fader.sv
// one led channel current fader: steps the active level toward the target
`timescale 1ns/1ps
module chgcfg_fader #(
  parameter int LEVEL_W = 7,
  parameter int TICK_W = 24,
  parameter int CLK_HZ = 20_000_000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [LEVEL_W-1:0] target,
  input wire logic fade_enable,
  input wire logic [2:0] rise_time,
  input wire logic [2:0] fall_time,
  output logic [LEVEL_W-1:0] level
);
  import chgcfg_pkg::*;

  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic [TICK_W-1:0] tick;
  } chgcfg_fader_t;

  chgcfg_fader_t state_reg;
  chgcfg_fader_t state_next;

  // cycles per one-level step; full scale is LEVEL_STEPS steps, floor keeps
  // the total at or under the programmed time, within one step period
  function automatic logic [TICK_W-1:0] step_cycles(input logic [2:0] code);
    longint cyc;
    cyc = (longint'(CLK_HZ) / 1000 * longint'(RAMP_MS[code])) / LEVEL_STEPS;
    if (cyc < MIN_TICK) begin
      cyc = MIN_TICK;
    end
    return cyc[TICK_W-1:0];
  endfunction : step_cycles

  // fading walks one level per step; zero time or disabled jumps at once
  always_comb begin
    logic rising;
    logic [2:0] code;
    rising = target > state_reg.level;
    code = rising ? rise_time : fall_time;
    state_next = state_reg;
    // [R13] per-channel enable
    if (!fade_enable || code == 3'h0) begin
      // [R16] immediate update
      state_next.level = target;
      state_next.tick = '0;
    end else if (target == state_reg.level) begin
      state_next.tick = '0;
    end else if (state_reg.tick + 1'b1 >= step_cycles(code)) begin
      // [R17] step period timing
      state_next.tick = '0;
      state_next.level = rising ? state_reg.level + 1'b1 : state_reg.level - 1'b1;
    end else begin
      state_next.tick = state_reg.tick + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.level;

endmodule : chgcfg_fader

// >>> dv/chgcfg_host.sv
// host model: one register read or write per call on the config bus
`timescale 1ns/1ps
module chgcfg_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle bus before the first access
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // request held over one rising edge; released lines turn over so nothing stale lingers
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : chgcfg_host

// >>> dv/chgcfg_checker.sv
// checker: decode, watchdog and fader relations at the bank's ports
`timescale 1ns/1ps
module chgcfg_checker (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [chgcfg_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [chgcfg_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic RECHARGE_ENABLE,
  input wire logic [8:0] RECHARGE_MV,
  input wire logic [10:0] FAST_CURRENT_MAX_MA,
  input wire logic [6:0] THERMAL_LIMIT_C,
  input wire logic [4:0] MOTOR_DRIVE_DV,
  input wire logic MOTOR_BYPASS,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic [6:0] CHAN_ONE_LEVEL,
  input wire logic CHAN_ONE_ON
);
  import chgcfg_pkg::*;
  logic charge_watchdog_enable_reg, fade_en_reg, slow_reg;
  logic [7:0] tgt_reg;

  // shadows of the gating bits, ramp codes and level one target, since the register bodies are hidden
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      charge_watchdog_enable_reg <= 1'b0;
      fade_en_reg <= 1'b0;
      slow_reg <= 1'b0;
      tgt_reg <= 8'h00;
    end else if (REG_WR) begin
      if (REG_ADDR == REGULATOR_CONTROL_ADDR) charge_watchdog_enable_reg <= REG_WDATA[6];
      if (REG_ADDR == FADE_TIMING_TWO_ADDR) fade_en_reg <= REG_WDATA[6];
      if (REG_ADDR == FADE_TIMING_ONE_ADDR) slow_reg <= |REG_WDATA[2:0] && |REG_WDATA[5:3];
      if (REG_ADDR == INDICATOR_ONE_LEVEL_ADDR) tgt_reg <= REG_WDATA;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence wr_a_s; REG_WR && REG_ADDR == CHARGER_SETUP_A_ADDR; endsequence
  sequence wr_b_s; REG_WR && REG_ADDR == CHARGER_SETUP_B_ADDR; endsequence
  sequence wr_f_s; REG_WR && REG_ADDR == FADE_TIMING_ONE_ADDR; endsequence
  sequence touch_s;
    (REG_WR || REG_RD) && (REG_ADDR == CHARGER_SETUP_A_ADDR || REG_ADDR == CHARGER_SETUP_B_ADDR);
  endsequence
  sequence lvl_wr_s; REG_WR && REG_ADDR == INDICATOR_ONE_LEVEL_ADDR && !fade_en_reg; endsequence

  // decodes follow the written codes one cycle later
  recharge_decode_a: assert property (
    wr_a_s |=> RECHARGE_ENABLE == ($past(REG_WDATA[4:3]) != 2'b11) && (!RECHARGE_ENABLE
      || RECHARGE_MV == 9'h0c8 + 9'h064 * $past(REG_WDATA[4:3])))
    else $error("restart threshold decode wrong");
  fast_current_a: assert property (
    wr_a_s ##0 (REG_WDATA[7:5] == 3'h0 || REG_WDATA[7:5] == 3'h5)
      |=> FAST_CURRENT_MAX_MA == ($past(REG_WDATA[5]) ? 11'h352 : 11'h05a))
    else $error("current ceiling decode wrong");
  thermal_limit_a: assert property (
    wr_b_s |=> THERMAL_LIMIT_C == 7'h46 + 7'h0f * $past(REG_WDATA[5:4]))
    else $error("thermal limit decode wrong");
  motor_level_a: assert property (
    wr_f_s |=> MOTOR_BYPASS == ($past(REG_WDATA[7:6]) == 2'b11) && (MOTOR_BYPASS
      || MOTOR_DRIVE_DV == ($past(REG_WDATA[7]) ? 5'h1e : $past(REG_WDATA[6]) ? 5'h19 : 5'h0d)))
    else $error("motor level decode wrong");
  // watchdog: charger access restarts it, and it only fires when enabled
  wd_restart_a: assert property (
    touch_s |=> !WATCHDOG_EXPIRED [*4])
    else $error("watchdog not restarted");
  wd_enable_a: assert property (
    $rose(WATCHDOG_EXPIRED) |-> $past(charge_watchdog_enable_reg))
    else $error("watchdog fired while disabled");
  // fader: immediate with fading off, each new level held at least 8 cycles with it on
  fade_off_a: assert property (
    lvl_wr_s |=> (CHAN_ONE_ON == tgt_reg[7]) ##[0:1] (CHAN_ONE_LEVEL == tgt_reg[6:0]))
    else $error("level not applied at once");
  fade_step_a: assert property (
    $changed(CHAN_ONE_LEVEL) && fade_en_reg && slow_reg |=> $stable(CHAN_ONE_LEVEL) [*8])
    else $error("fader stepped too fast");
endmodule : chgcfg_checker

bind chgcfg_top chgcfg_checker chk (
  .CLK(CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .RECHARGE_ENABLE(RECHARGE_ENABLE), .RECHARGE_MV(RECHARGE_MV),
  .FAST_CURRENT_MAX_MA(FAST_CURRENT_MAX_MA), .THERMAL_LIMIT_C(THERMAL_LIMIT_C),
  .MOTOR_DRIVE_DV(MOTOR_DRIVE_DV), .MOTOR_BYPASS(MOTOR_BYPASS),
  .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED), .CHAN_ONE_LEVEL(CHAN_ONE_LEVEL), .CHAN_ONE_ON(CHAN_ONE_ON)
);

// >>> dv/chgcfg_top_tb_top.sv
// testbench: registers, decodes, timers, watchdog and fader of the config bank
`timescale 1ns/1ps
module chgcfg_top_tb_top;
  import chgcfg_pkg::*;
  // cycles per fader step for ramp code 001 at 20 MHz
  localparam int STEP = 20000 * 128 / 127;
  logic clk, rst_b, reg_wr, reg_rd, fast_act, top_act, chg_en, recharge_en;
  logic motor_bypass, fast_exp, fin_exp, wd_exp, on_one, on_two;
  logic [1:0] topoff_sel;
  logic [8:0] recharge_mv;
  logic [10:0] cur_ma;
  logic [12:0] volt_mv;
  logic [6:0] therm_c, lvl_one, lvl_two;
  logic [4:0] motor_dv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_q, a, b, f;
  logic [7:0] map_a [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h05, 8'h10, 8'hff};
  logic [7:0] map_v [9] = '{8'h1f, 8'h20, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  int miscompares = 0;
  int comparisons = 0;

  chgcfg_top #(.WATCHDOG_CYCLES(50), .MINUTE_CYCLES(20)) uut (
    .CLK(clk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .FAST_CHARGE_ACTIVE(fast_act),
    .TOP_OFF_ACTIVE(top_act), .CHARGER_ENABLE(chg_en), .TOP_OFF_SEL(topoff_sel),
    .RECHARGE_ENABLE(recharge_en), .RECHARGE_MV(recharge_mv), .FAST_CURRENT_MAX_MA(cur_ma),
    .CHARGE_VOLTAGE_MV(volt_mv), .THERMAL_LIMIT_C(therm_c), .MOTOR_DRIVE_DV(motor_dv),
    .MOTOR_BYPASS(motor_bypass), .FAST_TIMER_EXPIRED(fast_exp), .FINISH_TIMER_EXPIRED(fin_exp),
    .WATCHDOG_EXPIRED(wd_exp), .CHAN_ONE_LEVEL(lvl_one), .CHAN_TWO_LEVEL(lvl_two),
    .CHAN_ONE_ON(on_one), .CHAN_TWO_ON(on_two)
  );
  chgcfg_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // compare and count; four-state equality so an unknown never matches
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // expected current ceiling and charge voltage of the standard variant
  function automatic logic [15:0] exp_cur(input logic [2:0] c);
    logic [15:0] t [8];
    t = '{16'h005a, 16'h010e, 16'h01c2, 16'h0276, 16'h02fd, 16'h0352, 16'h0078, 16'h00b4};
    return t[c];
  endfunction : exp_cur
  function automatic logic [15:0] exp_volt(input logic [1:0] c);
    logic [15:0] t [4];
    t = '{16'h0dac, 16'h0f0a, 16'h0fd2, 16'h104a};
    return t[c];
  endfunction : exp_volt

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    host.access(1'b1, adr, d, rd_q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] want);
    host.access(1'b0, adr, 8'h00, rd_q);
    check("read data", rd_q, want);
  endtask : rd_chk

  // every decode against the register values last written
  task automatic chk_dec(input logic [7:0] ra, input logic [7:0] rb, input logic [7:0] rf);
    check("charger enable", chg_en, ra[0]);
    check("top-off select", topoff_sel, ra[2:1]);
    check("recharge enable", recharge_en, ra[4:3] != 2'b11);
    if (ra[4:3] != 2'b11) check("recharge mv", recharge_mv, 16'h00c8 + 16'h0064 * ra[4:3]);
    check("current ceiling", cur_ma, exp_cur(ra[7:5]));
    check("charge voltage", volt_mv, exp_volt(rb[1:0]));
    check("thermal limit", therm_c, 16'h0046 + 16'h000f * rb[5:4]);
    check("motor bypass", motor_bypass, rf[7:6] == 2'b11);
    if (rf[7:6] != 2'b11) check("motor level", motor_dv, rf[7] ? 5'h1e : rf[6] ? 5'h19 : 5'h0d);
  endtask : chk_dec

  // run one charge phase against its limit; a free minute prescaler gives some slack
  task automatic run_timer(input logic fin, input int c);
    int lim;
    lim = (fin ? 600 : 1200) << c;
    if (fin) top_act = 1'b1;
    else fast_act = 1'b1;
    repeat (lim - 25) @(negedge clk);
    check("timer flag early", fin ? fin_exp : fast_exp, 1'b0);
    repeat (50) @(negedge clk);
    check("timer flag", fin ? fin_exp : fast_exp, c != 3);
    top_act = 1'b0;
    fast_act = 1'b0;
  endtask : run_timer

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h9bf7_6f44));
    rst_b = 1'b0;
    fast_act = 1'b0;
    top_act = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    // reset values, unmapped pointers and an ignored write
    wr(8'h10, 8'h5a);
    foreach (map_a[i]) rd_chk(map_a[i], map_v[i]);
    chk_dec(8'h1f, 8'h20, 8'h80);
    // random codes with both extremes first
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      f = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      wr(CHARGER_SETUP_A_ADDR, a);
      wr(CHARGER_SETUP_B_ADDR, b);
      wr(FADE_TIMING_ONE_ADDR, f);
      rd_chk(CHARGER_SETUP_A_ADDR, a);
      rd_chk(CHARGER_SETUP_B_ADDR, b);
      rd_chk(FADE_TIMING_ONE_ADDR, f);
      chk_dec(a, b, f);
    end
    // watchdog: restarted by a read, fires when idle, silent once disabled
    wr(REGULATOR_CONTROL_ADDR, 8'hc0);
    repeat (40) @(negedge clk);
    host.access(1'b0, CHARGER_SETUP_A_ADDR, 8'h00, rd_q);
    repeat (40) @(negedge clk);
    check("watchdog flag", wd_exp, 1'b0);
    repeat (20) @(negedge clk);
    check("watchdog flag", wd_exp, 1'b1);
    host.access(1'b0, CHARGER_SETUP_B_ADDR, 8'h00, rd_q);
    check("watchdog flag", wd_exp, 1'b0);
    wr(REGULATOR_CONTROL_ADDR, 8'h80);
    repeat (100) @(negedge clk);
    check("watchdog flag", wd_exp, 1'b0);
    // both charge timers through every limit code
    for (int c = 0; c < 4; c++) begin
      wr(CHARGER_SETUP_B_ADDR, {2'(c), 2'b10, 2'(c), 2'b00});
      run_timer(1'b0, c);
      run_timer(1'b1, c);
    end
    // fading off: new levels apply at once
    wr(FADE_TIMING_TWO_ADDR, 8'h00);
    wr(INDICATOR_ONE_LEVEL_ADDR, 8'hc5);
    wr(INDICATOR_TWO_LEVEL_ADDR, 8'hb3);
    @(negedge clk);
    check("level one", lvl_one, 7'h45);
    check("channel one on", on_one, 1'b1);
    check("channel two on", on_two, 1'b1);
    check("level two", lvl_two, 7'h33);
    // fading on: one channel falls, the other rises, each on its own code
    wr(FADE_TIMING_ONE_ADDR, 8'h8f);
    wr(FADE_TIMING_TWO_ADDR, 8'hf9);
    wr(INDICATOR_ONE_LEVEL_ADDR, 8'h80);
    wr(INDICATOR_TWO_LEVEL_ADDR, 8'h7f);
    repeat (STEP * 3 / 2) @(negedge clk);
    check("level one fading", lvl_one === 7'h44 || lvl_one === 7'h43, 1'b1);
    check("level two fading", lvl_two === 7'h34 || lvl_two === 7'h35, 1'b1);
    end_of_test();
  end
endmodule : chgcfg_top_tb_top
